/* File: hdl/hec_pkg.sv */
package hec_pkg;

	// Major opcodes of the 32-bit base encoding
	localparam logic [6:0] HEC_OPC_LUI   = 7'h37;
	localparam logic [6:0] HEC_OPC_AUIPC = 7'h17;
	localparam logic [6:0] HEC_OPC_OPIMM = 7'h13;
	localparam logic [6:0] HEC_OPC_OP    = 7'h33;
	localparam logic [6:0] HEC_OPC_FENCE = 7'h0f;

	// Minor function codes
	localparam logic [2:0] HEC_F3_ADD   = 3'h0;
	localparam logic [2:0] HEC_F3_SLL   = 3'h1;
	localparam logic [2:0] HEC_F3_SLT   = 3'h2;
	localparam logic [2:0] HEC_F3_SLTU  = 3'h3;
	localparam logic [2:0] HEC_F3_XOR   = 3'h4;
	localparam logic [2:0] HEC_F3_SR    = 3'h5;
	localparam logic [2:0] HEC_F3_OR    = 3'h6;
	localparam logic [2:0] HEC_F3_AND   = 3'h7;
	localparam logic [2:0] HEC_F3_FENCE = 3'h0;
	localparam logic [6:0] HEC_F7_BASE  = 7'h00;
	localparam logic [6:0] HEC_F7_ALT   = 7'h20;

	// Field positions in the instruction word
	localparam int HEC_REG_W    = 5;
	localparam int HEC_OPC_LSB  = 0;
	localparam int HEC_RD_LSB   = 7;
	localparam int HEC_F3_LSB   = 12;
	localparam int HEC_RS1_LSB  = 15;
	localparam int HEC_RS2_LSB  = 20;
	localparam int HEC_F7_LSB   = 25;
	localparam int HEC_IMM_LSB  = 20;
	localparam int HEC_IMM_W    = 12;
	localparam int HEC_SUCC_LSB = 20;
	localparam int HEC_PRED_LSB = 24;
	localparam int HEC_FM_LSB   = 28;
	localparam int HEC_SET_W    = 4;

	// Register numbers and field values
	localparam logic [4:0]  HEC_X0        = 5'h00;
	localparam logic [4:0]  HEC_X2        = 5'h02;
	localparam logic [4:0]  HEC_X3        = 5'h03;
	localparam logic [4:0]  HEC_X4        = 5'h04;
	localparam logic [4:0]  HEC_X5        = 5'h05;
	localparam logic [3:0]  HEC_FM_NORMAL = 4'h0;
	localparam logic [3:0]  HEC_SET_NONE  = 4'h0;
	localparam logic [11:0] HEC_IMM_ZERO  = 12'h000;
	localparam logic [4:0]  HEC_SH_ENTRY  = 5'h1f;
	localparam logic [4:0]  HEC_SH_EXIT   = 5'h07;

	// Hint class
	typedef enum logic [1:0]
	{
		HEC_CLS_NONE   = 2'h0,
		HEC_CLS_STD    = 2'h1,
		HEC_CLS_CUSTOM = 2'h2
	} hec_class_t;

	// Non-temporal locality variant
	typedef enum logic [2:0]
	{
		HEC_LOC_NONE = 3'h0,
		HEC_LOC_P1   = 3'h1,
		HEC_LOC_PALL = 3'h2,
		HEC_LOC_S1   = 3'h3,
		HEC_LOC_ALL  = 3'h4
	} hec_loc_t;

	// Zero register test
	function automatic logic hec_is_x0(input logic [4:0] r);
		return r == HEC_X0;
	endfunction : hec_is_x0

endpackage : hec_pkg

/* File: hdl/hec_classify.sv */
`timescale 1ns/100ps
module hec_classify
	import hec_pkg::*;
(
	input  wire logic [31:0] instr,
	output hec_class_t       cls,
	output hec_loc_t         loc,
	output logic             fence_no_order,
	output logic             semihost_mark
);

	logic [6:0]  opc;
	logic [4:0]  rd;
	logic [4:0]  rs1;
	logic [4:0]  rs2;
	logic [2:0]  f3;
	logic [6:0]  f7;
	logic [11:0] imm;
	logic [3:0]  succ;
	logic [3:0]  pred;
	logic [3:0]  fm;
	logic        rd0;
	logic        rs10;
	logic        is_fence;

	// Field split
	assign opc  = instr[HEC_OPC_LSB +: 7];
	assign rd   = instr[HEC_RD_LSB +: HEC_REG_W];
	assign rs1  = instr[HEC_RS1_LSB +: HEC_REG_W];
	assign rs2  = instr[HEC_RS2_LSB +: HEC_REG_W];
	assign f3   = instr[HEC_F3_LSB +: 3];
	assign f7   = instr[HEC_F7_LSB +: 7];
	assign imm  = instr[HEC_IMM_LSB +: HEC_IMM_W];
	assign succ = instr[HEC_SUCC_LSB +: HEC_SET_W];
	assign pred = instr[HEC_PRED_LSB +: HEC_SET_W];
	assign fm   = instr[HEC_FM_LSB +: HEC_SET_W];
	assign rd0  = hec_is_x0(rd);
	assign rs10 = hec_is_x0(rs1);
	assign is_fence = (opc == HEC_OPC_FENCE) && (f3 == HEC_F3_FENCE);

	// Class decode; pure logic so decode never stalls
	always_comb
	begin
		cls = HEC_CLS_NONE;
		loc = HEC_LOC_NONE;
		case (opc)
			HEC_OPC_LUI, HEC_OPC_AUIPC:
				if (rd0)
					cls = HEC_CLS_STD;
			HEC_OPC_OPIMM:
				if (rd0)
				begin
					case (f3)
						// Plain nop stays a nop
						HEC_F3_ADD:
							if (!(rs10 && imm == HEC_IMM_ZERO))
								cls = HEC_CLS_STD;
						HEC_F3_XOR, HEC_F3_OR, HEC_F3_AND:
							cls = HEC_CLS_STD;
						HEC_F3_SLT, HEC_F3_SLTU:
							cls = HEC_CLS_CUSTOM;
						HEC_F3_SLL:
							if (f7 == HEC_F7_BASE)
								cls = HEC_CLS_CUSTOM;
						HEC_F3_SR:
							if (f7 == HEC_F7_BASE || f7 == HEC_F7_ALT)
								cls = HEC_CLS_CUSTOM;
						default:
							cls = HEC_CLS_NONE;
					endcase
				end
			HEC_OPC_OP:
				// Only defined funct7 forms count
				if (rd0 && (f7 == HEC_F7_BASE || (f7 == HEC_F7_ALT
					&& (f3 == HEC_F3_ADD || f3 == HEC_F3_SR))))
				begin
					if (f3 == HEC_F3_SLT || f3 == HEC_F3_SLTU)
						cls = HEC_CLS_CUSTOM;
					else
						cls = HEC_CLS_STD;
					if (f3 == HEC_F3_ADD && f7 == HEC_F7_BASE && rs10)
					begin
						case (rs2)
							HEC_X2: loc = HEC_LOC_P1;
							HEC_X3: loc = HEC_LOC_PALL;
							HEC_X4: loc = HEC_LOC_S1;
							HEC_X5: loc = HEC_LOC_ALL;
							default: loc = HEC_LOC_NONE;
						endcase
					end
				end
			HEC_OPC_FENCE:
				// Both rd and rs1 nonzero is outside the hint space
				if (is_fence && fm == HEC_FM_NORMAL
					&& (pred == HEC_SET_NONE || succ == HEC_SET_NONE)
					&& (rd0 || rs10))
					cls = HEC_CLS_STD;
			default:
				cls = HEC_CLS_NONE;
		endcase
	end

	// Reserved fm is read as fm zero, so an empty set orders nothing
	assign fence_no_order = is_fence
		&& (pred == HEC_SET_NONE || succ == HEC_SET_NONE);

	// Semihosting entry and exit markers, flagged for custom users
	assign semihost_mark = (opc == HEC_OPC_OPIMM) && rd0 && rs10
		&& ((f3 == HEC_F3_SLL && f7 == HEC_F7_BASE && rs2 == HEC_SH_ENTRY)
		|| (f3 == HEC_F3_SR && f7 == HEC_F7_ALT && rs2 == HEC_SH_EXIT));

endmodule : hec_classify

/* File: hdl/hec_top.sv */
// Contract
// - Retired hints change nothing but pc and performance counters.
// - Core may ignore any hint's meaning entirely.
// - Integer computational ops writing x0 are hint code points.
// - FENCE with fm zero and empty pred or succ is a hint; the decode also requires rd or rs1 at x0.
// - ADD-class hints may simply execute as ADD writing x0.
// - Register hint source fields pass unchanged to hint consumers.
// - FENCE pred zero, fm zero is a hint; succ, rs1, rd are arguments.
// - Fence with an empty set must not stall or reorder accesses.
// - ADDI x0 hint only if rs1 nonzero or immediate nonzero.
// - ADD x0,x0,x2..x5 decodes to four non-temporal locality variants.
// - FENCE rd x0, rs1 nonzero, fm zero, empty set is standard hint.
// - Set-less-than and immediate-shift x0 forms are custom hints.
// - fm 0000 is normal; reserved configurations act as fm zero; the decode orders them so but never flags a reserved-fm fence as a hint.
`timescale 1ns/100ps
module hec_top
	import hec_pkg::*;
#(
	parameter int CNT_W = 32
)
(
	input  wire logic             CLK,
	input  wire logic             RESET,
	input  wire logic             CE,
	input  wire logic [31:0]      INSTR,
	input  wire logic             INSTR_VALID,
	input  wire logic             RETIRE_VALID,
	input  wire logic             RETIRE_HINT,
	output logic                  HINT,
	output hec_class_t            HINT_CLASS,
	output hec_loc_t              LOCALITY,
	output logic [4:0]            ARG_RS1,
	output logic [4:0]            ARG_RS2,
	output logic [4:0]            ARG_RD,
	output logic [3:0]            ARG_SUCC,
	output logic                  FENCE_NO_ORDER,
	output logic                  SEMIHOST_MARK,
	output logic [CNT_W-1:0]      HINT_COUNT
);

	hec_class_t       cls;
	hec_loc_t         loc;
	logic             no_order;
	logic             semi;
	logic [CNT_W-1:0] count_d;
	logic [CNT_W-1:0] count_q;

	// Decode sits beside normal decode; it does not touch the datapath,
	// so a hint still runs as its base op writing x0
	hec_classify u_classify
	(
		.instr          (INSTR),
		.cls            (cls),
		.loc            (loc),
		.fence_no_order (no_order),
		.semihost_mark  (semi)
	);

	// Qualified flags; combinational so no extra stage is added
	always_comb
	begin
		HINT       = INSTR_VALID && cls != HEC_CLS_NONE;
		HINT_CLASS = INSTR_VALID ? cls : HEC_CLS_NONE;
		LOCALITY   = INSTR_VALID ? loc : HEC_LOC_NONE;
		FENCE_NO_ORDER = INSTR_VALID && no_order;
		SEMIHOST_MARK  = INSTR_VALID && semi;
	end

	// Argument fields go out untouched; zero when no hint
	always_comb
	begin
		ARG_RS1  = HINT ? INSTR[HEC_RS1_LSB +: HEC_REG_W] : HEC_X0;
		ARG_RS2  = HINT ? INSTR[HEC_RS2_LSB +: HEC_REG_W] : HEC_X0;
		ARG_RD   = HINT ? INSTR[HEC_RD_LSB +: HEC_REG_W] : HEC_X0;
		ARG_SUCC = HINT ? INSTR[HEC_SUCC_LSB +: HEC_SET_W]
			: HEC_SET_NONE;
	end

	// Retired-hint counter: the only state a hint may advance
	always_comb
	begin
		count_d = count_q;
		if (RETIRE_VALID && RETIRE_HINT)
			count_d = count_q + CNT_W'(1);
	end

	// Counter register; CE low freezes it
	always_ff @(posedge CLK)
	begin
		if (RESET)
			count_q <= '0;
		else if (CE)
			count_q <= count_d;
	end

	assign HINT_COUNT = count_q;

	// Checks on the decode and the counter
	a_nop_not_hint: assert property (@(posedge CLK) disable iff (RESET)
		(INSTR == {HEC_IMM_ZERO, HEC_X0, HEC_F3_ADD, HEC_X0, HEC_OPC_OPIMM})
		|-> !HINT)
		else $error("canonical nop flagged as hint");

	a_addi_x0_hint: assert property (@(posedge CLK) disable iff (RESET)
		(INSTR_VALID && INSTR[6:0] == HEC_OPC_OPIMM && INSTR[14:12] == 3'h0
		&& INSTR[11:7] == HEC_X0 && INSTR[19:15] != HEC_X0)
		|-> HINT && HINT_CLASS == HEC_CLS_STD)
		else $error("addi x0 with nonzero source not a standard hint");

	a_rd_is_x0: assert property (@(posedge CLK) disable iff (RESET)
		(HINT && INSTR[6:0] != HEC_OPC_FENCE) |-> INSTR[11:7] == HEC_X0)
		else $error("non-fence hint with nonzero destination");

	a_locality_map: assert property (@(posedge CLK) disable iff (RESET)
		(INSTR_VALID && INSTR[31:25] == HEC_F7_BASE && INSTR[14:0]
		== {HEC_X0, HEC_F3_ADD, HEC_X0, HEC_OPC_OP}
		&& INSTR[24:20] >= HEC_X2 && INSTR[24:20] <= HEC_X5)
		|-> LOCALITY == hec_loc_t'(INSTR[22:20] - 3'h1))
		else $error("locality variant mismatched to rs2");

	a_custom_slt: assert property (@(posedge CLK) disable iff (RESET)
		(INSTR_VALID && INSTR[6:0] == HEC_OPC_OPIMM && INSTR[11:7] == HEC_X0
		&& (INSTR[14:12] == HEC_F3_SLT || INSTR[14:12] == HEC_F3_SLTU))
		|-> HINT_CLASS == HEC_CLS_CUSTOM)
		else $error("slti x0 not classified custom");

	a_fence_hint: assert property (@(posedge CLK) disable iff (RESET)
		(INSTR_VALID && INSTR[6:0] == HEC_OPC_FENCE && INSTR[14:12] == 3'h0
		&& INSTR[31:28] == HEC_FM_NORMAL && INSTR[11:7] == HEC_X0
		&& INSTR[19:15] != HEC_X0 && INSTR[27:24] == HEC_SET_NONE)
		|-> HINT && HINT_CLASS == HEC_CLS_STD && FENCE_NO_ORDER)
		else $error("null-predecessor fence not a standard hint");

	a_args_pass: assert property (@(posedge CLK) disable iff (RESET)
		HINT |-> ARG_RS1 == INSTR[19:15] && ARG_RS2 == INSTR[24:20]
		&& ARG_RD == INSTR[11:7])
		else $error("hint arguments altered");

	a_flag_class: assert property (@(posedge CLK) disable iff (RESET)
		HINT == (HINT_CLASS != HEC_CLS_NONE))
		else $error("hint flag and class disagree");

	a_count_step: assert property (@(posedge CLK) disable iff (RESET)
		(CE && RETIRE_VALID && RETIRE_HINT) |=>
		HINT_COUNT == $past(HINT_COUNT) + CNT_W'(1))
		else $error("retired hint not counted");

	a_count_hold: assert property (@(posedge CLK) disable iff (RESET)
		(!CE || !(RETIRE_VALID && RETIRE_HINT)) |=> $stable(HINT_COUNT))
		else $error("hint counter moved without a retired hint");

	// Raw fields for the checks, split apart from the classifier so a
	// decode slip there cannot hide behind its own field split
	logic [6:0] chk_opc;
	logic [4:0] chk_rd;
	logic [4:0] chk_rs1;
	logic [2:0] chk_f3;
	logic [6:0] chk_f7;
	logic [3:0] chk_succ;
	logic [3:0] chk_pred;
	logic [3:0] chk_fm;
	logic       chk_fence;

	assign chk_opc   = INSTR[HEC_OPC_LSB +: 7];
	assign chk_rd    = INSTR[HEC_RD_LSB +: HEC_REG_W];
	assign chk_rs1   = INSTR[HEC_RS1_LSB +: HEC_REG_W];
	assign chk_f3    = INSTR[HEC_F3_LSB +: 3];
	assign chk_f7    = INSTR[HEC_F7_LSB +: 7];
	assign chk_succ  = INSTR[HEC_SUCC_LSB +: HEC_SET_W];
	assign chk_pred  = INSTR[HEC_PRED_LSB +: HEC_SET_W];
	assign chk_fm    = INSTR[HEC_FM_LSB +: HEC_SET_W];
	assign chk_fence = INSTR_VALID && chk_opc == HEC_OPC_FENCE
		&& chk_f3 == HEC_F3_FENCE;

	a_logic_imm: assert property (@(posedge CLK) disable iff (RESET)
		(INSTR_VALID && chk_opc == HEC_OPC_OPIMM && chk_rd == HEC_X0
		&& (chk_f3 == HEC_F3_XOR || chk_f3 == HEC_F3_OR
		|| chk_f3 == HEC_F3_AND))
		|-> HINT && HINT_CLASS == HEC_CLS_STD)
		else $error("logical immediate to x0 not a standard hint");

	a_upper_imm: assert property (@(posedge CLK) disable iff (RESET)
		(INSTR_VALID && chk_rd == HEC_X0
		&& (chk_opc == HEC_OPC_LUI || chk_opc == HEC_OPC_AUIPC))
		|-> HINT && HINT_CLASS == HEC_CLS_STD)
		else $error("upper immediate to x0 not a standard hint");

	a_reg_std: assert property (@(posedge CLK) disable iff (RESET)
		(INSTR_VALID && chk_opc == HEC_OPC_OP && chk_rd == HEC_X0
		&& chk_f7 == HEC_F7_BASE && chk_f3 != HEC_F3_SLT
		&& chk_f3 != HEC_F3_SLTU)
		|-> HINT && HINT_CLASS == HEC_CLS_STD)
		else $error("register op to x0 not a standard hint");

	a_alt_std: assert property (@(posedge CLK) disable iff (RESET)
		(INSTR_VALID && chk_opc == HEC_OPC_OP && chk_rd == HEC_X0
		&& chk_f7 == HEC_F7_ALT
		&& (chk_f3 == HEC_F3_ADD || chk_f3 == HEC_F3_SR))
		|-> HINT && HINT_CLASS == HEC_CLS_STD)
		else $error("subtract or arithmetic shift to x0 not a hint");

	a_shift_custom: assert property (@(posedge CLK) disable iff (RESET)
		(INSTR_VALID && chk_opc == HEC_OPC_OPIMM && chk_rd == HEC_X0
		&& ((chk_f3 == HEC_F3_SLL && chk_f7 == HEC_F7_BASE)
		|| (chk_f3 == HEC_F3_SR
		&& (chk_f7 == HEC_F7_BASE || chk_f7 == HEC_F7_ALT))))
		|-> HINT && HINT_CLASS == HEC_CLS_CUSTOM)
		else $error("shift immediate to x0 not a custom hint");

	a_reg_slt: assert property (@(posedge CLK) disable iff (RESET)
		(INSTR_VALID && chk_opc == HEC_OPC_OP && chk_rd == HEC_X0
		&& chk_f7 == HEC_F7_BASE
		&& (chk_f3 == HEC_F3_SLT || chk_f3 == HEC_F3_SLTU))
		|-> HINT && HINT_CLASS == HEC_CLS_CUSTOM)
		else $error("register set-less-than to x0 not a custom hint");

	// Fence hints: one register field at x0 and one set left empty
	a_fence_no_pred: assert property (@(posedge CLK) disable iff (RESET)
		(chk_fence && chk_fm == HEC_FM_NORMAL && chk_pred == HEC_SET_NONE
		&& (chk_rd == HEC_X0 || chk_rs1 == HEC_X0))
		|-> HINT && HINT_CLASS == HEC_CLS_STD && FENCE_NO_ORDER
		&& ARG_SUCC == chk_succ)
		else $error("null-predecessor fence hint wrong");

	a_fence_no_succ: assert property (@(posedge CLK) disable iff (RESET)
		(chk_fence && chk_fm == HEC_FM_NORMAL && chk_succ == HEC_SET_NONE
		&& (chk_rd == HEC_X0 || chk_rs1 == HEC_X0))
		|-> HINT && HINT_CLASS == HEC_CLS_STD && FENCE_NO_ORDER)
		else $error("null-successor fence not a standard hint");

	a_fence_regs: assert property (@(posedge CLK) disable iff (RESET)
		(chk_fence && chk_rd != HEC_X0 && chk_rs1 != HEC_X0) |-> !HINT)
		else $error("fence with both register fields set flagged");

	// Reserved modes are never hints but order as a normal fence would
	a_fence_mode: assert property (@(posedge CLK) disable iff (RESET)
		(chk_fence && chk_fm != HEC_FM_NORMAL)
		|-> !HINT && FENCE_NO_ORDER == (chk_pred == HEC_SET_NONE
		|| chk_succ == HEC_SET_NONE))
		else $error("reserved fence mode not treated as normal fence");

	a_full_fence: assert property (@(posedge CLK) disable iff (RESET)
		(chk_fence && chk_pred != HEC_SET_NONE && chk_succ != HEC_SET_NONE)
		|-> !HINT && !FENCE_NO_ORDER)
		else $error("ordering fence flagged as unordered hint");

	a_locality_form: assert property (@(posedge CLK) disable iff (RESET)
		(LOCALITY != HEC_LOC_NONE)
		|-> INSTR_VALID && chk_opc == HEC_OPC_OP && chk_rd == HEC_X0
		&& chk_rs1 == HEC_X0 && chk_f3 == HEC_F3_ADD
		&& chk_f7 == HEC_F7_BASE)
		else $error("locality variant on a non-locality word");

	a_semihost_custom: assert property (@(posedge CLK) disable iff (RESET)
		SEMIHOST_MARK |-> HINT && HINT_CLASS == HEC_CLS_CUSTOM
		&& chk_rs1 == HEC_X0)
		else $error("semihosting marker not a custom hint");

	a_invalid_quiet: assert property (@(posedge CLK) disable iff (RESET)
		!INSTR_VALID |-> !HINT && LOCALITY == HEC_LOC_NONE
		&& !FENCE_NO_ORDER && !SEMIHOST_MARK && ARG_RS1 == HEC_X0
		&& ARG_RS2 == HEC_X0 && ARG_RD == HEC_X0
		&& ARG_SUCC == HEC_SET_NONE)
		else $error("decode outputs active without a valid word");

	// Not disabled by reset: this one watches the reset itself
	a_reset_clear: assert property (@(posedge CLK)
		RESET |=> HINT_COUNT == '0)
		else $error("hint counter not cleared by reset");

endmodule : hec_top

/* File: test/hec_retire_model.sv */
`timescale 1ns/100ps
module hec_retire_model
(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic instr_valid,
	input  wire logic hint,
	output logic      retire_valid,
	output logic      retire_hint
);
	logic valid_d;
	logic valid_q;
	logic hint_d;
	logic hint_q;

	// Every decoded word retires one cycle later, hint flag alongside
	// Hint meaning itself is ignored, nothing custom is assigned
	always_comb
	begin
		valid_d = instr_valid & ~reset;
		hint_d  = hint & instr_valid & ~reset;
	end

	// Register only; reset keeps stray retirements out of the counter
	always_ff @(posedge clk)
	begin
		valid_q <= valid_d;
		hint_q  <= hint_d;
	end

	assign retire_valid = valid_q;
	assign retire_hint  = hint_q;
endmodule : hec_retire_model

/* File: test/testbench.sv */
`timescale 1ns/100ps
module testbench;
	import hec_pkg::*;
	logic        clk, reset, ce, instr_valid, retire_valid, retire_hint;
	logic        hint, fence_no_order, semihost_mark;
	logic [31:0] instr, hint_count;
	logic [4:0]  arg_rs1, arg_rs2, arg_rd;
	logic [3:0]  arg_succ;
	hec_class_t  hint_class;
	hec_loc_t    locality;
	int          bad_count = 0;
	int          tests_run = 0;
	int          exp_count = 0;

	hec_top #(.CNT_W(32)) hec_top_i (.CLK(clk), .RESET(reset), .CE(ce),
		.INSTR(instr), .INSTR_VALID(instr_valid),
		.RETIRE_VALID(retire_valid), .RETIRE_HINT(retire_hint),
		.HINT(hint), .HINT_CLASS(hint_class), .LOCALITY(locality),
		.ARG_RS1(arg_rs1), .ARG_RS2(arg_rs2), .ARG_RD(arg_rd),
		.ARG_SUCC(arg_succ), .FENCE_NO_ORDER(fence_no_order),
		.SEMIHOST_MARK(semihost_mark), .HINT_COUNT(hint_count));

	hec_retire_model hec_retire_model_i (.clk(clk), .reset(reset),
		.instr_valid(instr_valid), .hint(hint),
		.retire_valid(retire_valid), .retire_hint(retire_hint));

	// Free-running core clock, 100 ns period
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [31:0] enc(input logic [6:0] f7,
		input logic [4:0] rs2, input logic [4:0] rs1,
		input logic [2:0] f3, input logic [6:0] opc);
		return {f7, rs2, rs1, f3, HEC_X0, opc};
	endfunction : enc

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h (#%0d)",
				$time, got, exp, bad_count);
		end
	endtask : cmp

	// Inputs move 1 ns after the edge; decode settles well before next
	task automatic put(input logic [31:0] w, input logic v);
		@(posedge clk);
		#1;
		instr       = w;
		instr_valid = v;
		#10;
	endtask : put

	task automatic hint_case(input logic [31:0] w, input hec_class_t c,
		input hec_loc_t l);
		logic h;
		h = (c != HEC_CLS_NONE);
		put(w, 1'b1);
		cmp(hint, h);
		cmp(hint_class, c);
		cmp(locality, l);
		cmp(arg_rs1, h ? w[19:15] : 5'h00);
		cmp(arg_rs2, h ? w[24:20] : 5'h00);
		cmp(arg_rd, h ? w[11:7] : 5'h00);
		cmp(arg_succ, h ? w[23:20] : 4'h0);
		if (h)
			exp_count++;
	endtask : hint_case

	task automatic t_register_ops();
		for (int n = 2; n <= 6; n++)
			hint_case(enc(HEC_F7_BASE, 5'(n), HEC_X0, HEC_F3_ADD,
				HEC_OPC_OP), HEC_CLS_STD,
				(n < 6) ? hec_loc_t'(n - 1) : HEC_LOC_NONE);
		hint_case(enc(HEC_F7_ALT, HEC_X3, 5'h01, HEC_F3_ADD, HEC_OPC_OP),
			HEC_CLS_STD, HEC_LOC_NONE);
		hint_case(32'h003100b3, HEC_CLS_NONE, HEC_LOC_NONE);
		hint_case(32'h12345037, HEC_CLS_STD, HEC_LOC_NONE);
		hint_case(32'habcde017, HEC_CLS_STD, HEC_LOC_NONE);
		hint_case(enc(HEC_F7_ALT, 5'h02, 5'h03, HEC_F3_SR, HEC_OPC_OP),
			HEC_CLS_STD, HEC_LOC_NONE);
		hint_case(enc(HEC_F7_BASE, 5'h02, 5'h03, HEC_F3_SLL, HEC_OPC_OP),
			HEC_CLS_STD, HEC_LOC_NONE);
		hint_case(enc(7'h01, 5'h02, 5'h03, HEC_F3_ADD, HEC_OPC_OP),
			HEC_CLS_NONE, HEC_LOC_NONE);
		// Logical immediates: XOR, OR and AND codes
		for (int f = 4; f < 8; f++)
			if (f != 5)
				hint_case(enc(7'h15, 5'h05, 5'h01, 3'(f), HEC_OPC_OPIMM),
					HEC_CLS_STD, HEC_LOC_NONE);
	endtask : t_register_ops

	// Canonical no-op stays out; either nonzero field makes it a hint
	task automatic t_addi();
		hint_case(32'h00000013, HEC_CLS_NONE, HEC_LOC_NONE);
		hint_case(32'h00008013, HEC_CLS_STD, HEC_LOC_NONE);
		hint_case(32'h00100013, HEC_CLS_STD, HEC_LOC_NONE);
	endtask : t_addi

	task automatic t_custom();
		for (int i = 0; i < 4; i++)
			hint_case(enc(HEC_F7_BASE, 5'h04, 5'h02, i[0] ? HEC_F3_SLTU :
				HEC_F3_SLT, i[1] ? HEC_OPC_OP : HEC_OPC_OPIMM),
				HEC_CLS_CUSTOM, HEC_LOC_NONE);
		hint_case(enc(HEC_F7_BASE, HEC_SH_ENTRY, HEC_X0, HEC_F3_SLL,
			HEC_OPC_OPIMM), HEC_CLS_CUSTOM, HEC_LOC_NONE);
		cmp(semihost_mark, 1'b1);
		hint_case(enc(HEC_F7_ALT, HEC_SH_EXIT, HEC_X0, HEC_F3_SR,
			HEC_OPC_OPIMM), HEC_CLS_CUSTOM, HEC_LOC_NONE);
		cmp(semihost_mark, 1'b1);
		hint_case(enc(HEC_F7_BASE, HEC_SH_EXIT, HEC_X0, HEC_F3_SR,
			HEC_OPC_OPIMM), HEC_CLS_CUSTOM, HEC_LOC_NONE);
		cmp(semihost_mark, 1'b0);
		hint_case(enc(HEC_F7_ALT, 5'h03, HEC_X0, HEC_F3_SLL,
			HEC_OPC_OPIMM), HEC_CLS_NONE, HEC_LOC_NONE);
	endtask : t_custom

	task automatic t_fence();
		hint_case({4'h0, 4'h0, 4'h3, 5'h01, HEC_F3_FENCE, HEC_X0,
			HEC_OPC_FENCE}, HEC_CLS_STD, HEC_LOC_NONE);
		cmp(fence_no_order, 1'b1);
		hint_case({4'h0, 4'h3, 4'h3, 5'h01, HEC_F3_FENCE, HEC_X0,
			HEC_OPC_FENCE}, HEC_CLS_NONE, HEC_LOC_NONE);
		cmp(fence_no_order, 1'b0);
		hint_case({4'h8, 4'h0, 4'h3, 5'h01, HEC_F3_FENCE, HEC_X0,
			HEC_OPC_FENCE}, HEC_CLS_NONE, HEC_LOC_NONE);
		cmp(fence_no_order, 1'b1);
		hint_case({4'h0, 4'h3, 4'h0, 5'h01, HEC_F3_FENCE, HEC_X0,
			HEC_OPC_FENCE}, HEC_CLS_STD, HEC_LOC_NONE);
		hint_case({4'h0, 4'h0, 4'h2, HEC_X0, HEC_F3_FENCE, 5'h01,
			HEC_OPC_FENCE}, HEC_CLS_STD, HEC_LOC_NONE);
		hint_case({4'h0, 4'h1, 4'h0, HEC_X0, HEC_F3_FENCE, HEC_X0,
			HEC_OPC_FENCE}, HEC_CLS_STD, HEC_LOC_NONE);
		hint_case({4'h0, 4'h0, 4'h2, 5'h01, HEC_F3_FENCE, 5'h01,
			HEC_OPC_FENCE}, HEC_CLS_NONE, HEC_LOC_NONE);
		cmp(fence_no_order, 1'b1);
	endtask : t_fence

	// Invalid word must silence every decode output
	task automatic gate_case(input logic [31:0] w);
		put(w, 1'b0);
		cmp({hint, hint_class, locality, fence_no_order}, 32'h0);
		cmp({arg_rs1, arg_rs2, arg_rd, arg_succ,
			semihost_mark}, 32'h0);
	endtask : gate_case

	// Locality, marker and fence words, each held with valid low
	task automatic t_gate();
		gate_case(32'h00200033);
		gate_case(enc(HEC_F7_BASE, HEC_SH_ENTRY, HEC_X0, HEC_F3_SLL,
			HEC_OPC_OPIMM));
		gate_case({4'h0, 4'h0, 4'h3, 5'h01, HEC_F3_FENCE, HEC_X0,
			HEC_OPC_FENCE});
	endtask : t_gate

	// Two cycles of retire latency, a frozen count with CE low, counting
	// again with CE high, then a reset in mid-run
	task automatic t_count();
		put(32'h0, 1'b0);
		repeat (3) @(posedge clk);
		#1;
		cmp(hint_count, 32'(exp_count));
		ce = 1'b0;
		put(32'h00200033, 1'b1);
		put(32'h0, 1'b0);
		repeat (3) @(posedge clk);
		#1;
		cmp(hint_count, 32'(exp_count));
		ce = 1'b1;
		hint_case(32'h00200033, HEC_CLS_STD, HEC_LOC_P1);
		put(32'h0, 1'b0);
		repeat (2) @(posedge clk);
		#1;
		cmp(hint_count, 32'(exp_count));
		reset = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		reset = 1'b0;
		cmp(hint_count, 32'h0);
	endtask : t_count

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	// Whole run is about 70 cycles; far beyond that means a hang
	initial
	begin
		#100000;
		bad_count++;
		print_verdict();
	end

	initial
	begin
		reset       = 1'b1;
		ce          = 1'b1;
		instr       = 32'h0;
		instr_valid = 1'b0;
		repeat (16) @(posedge clk);
		#1;
		reset = 1'b0;
		cmp(hint_count, 32'h0);
		t_register_ops();
		t_addi();
		t_custom();
		t_fence();
		t_gate();
		t_count();
		print_verdict();
	end
endmodule : testbench
